//--- logic/adccs_consts.vh
// constants for the converter clock and sequencing block
`ifndef ADCCS_CONSTS_VH
`define ADCCS_CONSTS_VH

// ----------------------------------------
// clock select field encodings
// ----------------------------------------
`define ADCCS_SEL_W 2
`define ADCCS_SEL_DIV2 2'h0
`define ADCCS_SEL_DIV8 2'h1
`define ADCCS_SEL_DIV32 2'h2
`define ADCCS_SEL_RC 2'h3

// ----------------------------------------
// sequencing counts, in bit periods
// ----------------------------------------
`define ADCCS_CONV_PERIODS 4'h9
`define ADCCS_RECOV_PERIODS 4'h2
`define ADCCS_CNT_W 4

// ----------------------------------------
// internal rc bit period
// ----------------------------------------
`define ADCCS_RC_PERIOD_NS 4000
`define ADCCS_CLK_PERIOD_NS 50
`define ADCCS_RC_CYCLES (`ADCCS_RC_PERIOD_NS / `ADCCS_CLK_PERIOD_NS)
`define ADCCS_RC_CNT_W 7

// ----------------------------------------
// reset values
// ----------------------------------------
`define ADCCS_DIV_RST 7'h00
`define ADCCS_PER_RST 4'h0

// ----------------------------------------
// state codes
// ----------------------------------------
`define ADCCS_ST_ACQ 2'h0
`define ADCCS_ST_CONV 2'h1
`define ADCCS_ST_RECOV 2'h2

`endif

//--- logic/adccs_ctrl.v
// converter bit-period clock, conversion sequencer and analog port masking
//
// Contract
// - each 10-bit conversion takes nine bit periods of the selected clock source.
// - the bit period is 2,8 or 32 oscillator periods, doubled to 4,16,64 by the extra select bit, or the undoubled rc source.
// - after a conversion the block waits two bit periods with the holding capacitor disconnected.
// - port reads return zero on every pin configured as an analog input.
// - conversion proceeds whatever the channel select and direction bits hold.
// - an analog pin left as output has its own driven level converted.
// - the rc source gives a bit period near 4 us, within 2 to 6 us.
`timescale 1ns/1ns
`include "adccs_consts.vh"

module adccs_ctrl #(
   parameter PINS = 5,
   parameter RC_CYCLES = `ADCCS_RC_CYCLES
) (
   // clock and reset
   input wire clock,
   input wire rst_b,
   // configuration
   input wire [1:0] conversion_clock_select,
   input wire conversion_clock_double_select,
   input wire [2:0] input_channel_select,
   input wire go,
   // port pins
   input wire [PINS-1:0] pin_level,
   input wire [PINS-1:0] pin_out_level,
   input wire [PINS-1:0] port_a_direction,
   input wire [PINS-1:0] analog_pin_config,
   // status
   output reg busy_ff,
   output reg done_ff,
   output reg bit_tick_ff,
   output reg holding_capacitor_connected_ff,
   output reg [2:0] sampled_channel_ff,
   output reg [PINS-1:0] sampled_level_ff,
   output reg [PINS-1:0] port_read_ff
);

   // ----------------------------------------
   // divisor decode
   // ----------------------------------------
   // divided-clock reload: 2^(2*sel+1+dbl)-1, one tick every 2^(2*sel+1+dbl) oscillator periods
   function [6:0] div_reload;
      input [1:0] sel;
      input dbl;
      begin
         case (sel)
            `ADCCS_SEL_DIV2: div_reload = dbl ? 7'h03 : 7'h01;
            `ADCCS_SEL_DIV8: div_reload = dbl ? 7'h0F : 7'h07;
            `ADCCS_SEL_DIV32: div_reload = dbl ? 7'h3F : 7'h1F;
            default: div_reload = RC_CYCLES[6:0] - 7'h01;
         endcase
      end
   endfunction

   // bit-period countdown shared by conversion and recovery
   function [`ADCCS_CNT_W-1:0] count_down;
      input [`ADCCS_CNT_W-1:0] cnt;
      begin
         count_down = cnt - 4'h1;
      end
   endfunction

   // the last period of a phase is the one that starts with a count of one
   function last_period;
      input [`ADCCS_CNT_W-1:0] cnt;
      begin
         last_period = (cnt == 4'h1);
      end
   endfunction

   reg [`ADCCS_RC_CNT_W-1:0] div_cnt_ff;
   reg [`ADCCS_RC_CNT_W-1:0] nxt_div_cnt;
   reg nxt_tick;
   reg [1:0] state_ff;
   reg [1:0] nxt_state;
   reg [`ADCCS_CNT_W-1:0] per_cnt_ff;
   reg [`ADCCS_CNT_W-1:0] nxt_per_cnt;
   reg nxt_done;
   wire [6:0] reload;
   wire start_take;

   // limitation: RC_CYCLES must stay at 128 or below to fit the divider count
   // rc source modelled as a fixed 4 us tick, inside the 2-6 us spread
   assign reload = div_reload(conversion_clock_select, conversion_clock_double_select);
   // a start is only taken while acquiring; go in any other state is dropped
   assign start_take = go && (state_ff == `ADCCS_ST_ACQ);

   // ----------------------------------------
   // bit-period tick generator
   // ----------------------------------------
   // divider restarts with go so the first period is a full one
   always @* begin
      nxt_tick = 1'b0;
      nxt_div_cnt = div_cnt_ff - 7'h01;
      if (start_take) begin
         nxt_div_cnt = reload;
      end else if (div_cnt_ff == 7'h00) begin
         nxt_tick = 1'b1;
         nxt_div_cnt = reload;
      end
   end

   // ----------------------------------------
   // conversion sequencer
   // ----------------------------------------
   // go during conversion or recovery is ignored; software owns acquisition timing
   always @* begin
      nxt_state = state_ff;
      nxt_per_cnt = per_cnt_ff;
      nxt_done = 1'b0;
      case (state_ff)
         `ADCCS_ST_ACQ: begin
            if (go) begin
               nxt_state = `ADCCS_ST_CONV;
               nxt_per_cnt = `ADCCS_CONV_PERIODS;
            end
         end
         `ADCCS_ST_CONV: begin
            if (nxt_tick) begin
               nxt_per_cnt = count_down(per_cnt_ff);
               if (last_period(per_cnt_ff)) begin
                  nxt_done = 1'b1;
                  nxt_state = `ADCCS_ST_RECOV;
                  nxt_per_cnt = `ADCCS_RECOV_PERIODS;
               end
            end
         end
         `ADCCS_ST_RECOV: begin
            if (nxt_tick) begin
               nxt_per_cnt = count_down(per_cnt_ff);
               if (last_period(per_cnt_ff)) begin
                  nxt_state = `ADCCS_ST_ACQ;
               end
            end
         end
         default: begin
            nxt_state = `ADCCS_ST_ACQ;
            nxt_per_cnt = 4'h0;
         end
      endcase
   end

   // ----------------------------------------
   // bit-period divider
   // ----------------------------------------
   // tick is registered so the status port shows a clean one-cycle pulse
   always @(posedge clock) begin
      if (!rst_b) begin
         div_cnt_ff <= `ADCCS_DIV_RST;
         bit_tick_ff <= 1'b0;
      end else begin
         div_cnt_ff <= nxt_div_cnt;
         bit_tick_ff <= nxt_tick;
      end
   end

   // ----------------------------------------
   // sequencer state
   // ----------------------------------------
   // state and period count move together so a phase never ends half counted
   always @(posedge clock) begin
      if (!rst_b) begin
         state_ff <= `ADCCS_ST_ACQ;
         per_cnt_ff <= `ADCCS_PER_RST;
      end else begin
         state_ff <= nxt_state;
         per_cnt_ff <= nxt_per_cnt;
      end
   end

   // ----------------------------------------
   // status outputs
   // ----------------------------------------
   // decoded from the next state so the flags line up with the state register
   always @(posedge clock) begin
      if (!rst_b) begin
         done_ff <= 1'b0;
         busy_ff <= 1'b0;
         holding_capacitor_connected_ff <= 1'b1;
      end else begin
         done_ff <= nxt_done;
         busy_ff <= (nxt_state == `ADCCS_ST_CONV);
         // capacitor only tracks the pin while acquiring
         holding_capacitor_connected_ff <= (nxt_state == `ADCCS_ST_ACQ);
      end
   end

   // ----------------------------------------
   // start capture
   // ----------------------------------------
   // channel and levels frozen at the start edge; later pin moves are not seen
   always @(posedge clock) begin
      if (!rst_b) begin
         sampled_channel_ff <= 3'h0;
         sampled_level_ff <= {PINS{1'b0}};
      end else if (start_take) begin
         // channel and direction never block a start
         sampled_channel_ff <= input_channel_select;
         // output pins feed back their own driven level
         sampled_level_ff <= (port_a_direction & pin_level) |
            (~port_a_direction & pin_out_level);
      end
   end

   // ----------------------------------------
   // port read path
   // ----------------------------------------
   // analog pins read low so a floating analog level never reaches software
   always @(posedge clock) begin
      if (!rst_b) begin
         port_read_ff <= {PINS{1'b0}};
      end else begin
         port_read_ff <= pin_level & ~analog_pin_config;
      end
   end

endmodule // adccs_ctrl

//--- testbench/adccs_ctrl_asserts.sv
// checker for the converter sequencer ports
`timescale 1ns/1ns
module adccs_ctrl_asserts #(parameter PINS = 5) (
   input wire clock,
   input wire rst_b,
   input wire go,
   input wire [2:0] input_channel_select,
   input wire [PINS-1:0] pin_level,
   input wire [PINS-1:0] pin_out_level,
   input wire [PINS-1:0] port_a_direction,
   input wire [PINS-1:0] analog_pin_config,
   input wire busy_ff,
   input wire done_ff,
   input wire bit_tick_ff,
   input wire holding_capacitor_connected_ff,
   input wire [2:0] sampled_channel_ff,
   input wire [PINS-1:0] sampled_level_ff,
   input wire [PINS-1:0] port_read_ff
);
   wire cap = holding_capacitor_connected_ff;
   reg [3:0] tk_ff;
   // ticks counted inside the busy window; the ninth lands with done
   always @(posedge clock) tk_ff <= (!rst_b || !busy_ff) ? 4'h0 : tk_ff + {3'h0, bit_tick_ff};
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_b);
   go_taken_a: assert property (go && cap && !busy_ff |=> busy_ff && !cap)
      else $error("start not taken");
   nine_ticks_a: assert property (done_ff |-> bit_tick_ff && tk_ff == 4'h8)
      else $error("done off the ninth tick");
   done_pulse_a: assert property (done_ff |-> $past(busy_ff) && !busy_ff ##1 !done_ff)
      else $error("done pulse wrong");
   recov_open_a: assert property (done_ff |-> !cap [*4])
      else $error("capacitor reconnected early");
   tick_pulse_a: assert property (bit_tick_ff |=> !bit_tick_ff)
      else $error("tick longer than a cycle");
   port_mask_a: assert property ($past(rst_b) |-> port_read_ff == $past(pin_level & ~analog_pin_config))
      else $error("analog pin read nonzero");
   chan_take_a: assert property ($rose(busy_ff) |-> sampled_channel_ff == $past(input_channel_select))
      else $error("channel not captured");
   level_take_a: assert property ($rose(busy_ff) |-> sampled_level_ff ==
      $past(pin_level & port_a_direction | pin_out_level & ~port_a_direction))
      else $error("converted level wrong");
endmodule // adccs_ctrl_asserts
bind adccs_ctrl adccs_ctrl_asserts #(.PINS(PINS)) u_chk (
   .clock(clock),
   .rst_b(rst_b),
   .go(go),
   .input_channel_select(input_channel_select),
   .pin_level(pin_level),
   .pin_out_level(pin_out_level),
   .port_a_direction(port_a_direction),
   .analog_pin_config(analog_pin_config),
   .busy_ff(busy_ff),
   .done_ff(done_ff),
   .bit_tick_ff(bit_tick_ff),
   .holding_capacitor_connected_ff(holding_capacitor_connected_ff),
   .sampled_channel_ff(sampled_channel_ff),
   .sampled_level_ff(sampled_level_ff),
   .port_read_ff(port_read_ff)
);

//--- testbench/adccs_ctrl_tb_top.sv
// self-checking bench for the converter sequencer
`timescale 1ns/1ns
module adccs_ctrl_tb_top;
   reg clock = 0, rst_b = 0, go = 0, conversion_clock_double_select = 0;
   reg [1:0] conversion_clock_select = 0;
   reg [2:0] input_channel_select = 0;
   reg [4:0] src_level = 5'h1B, port_a_direction = 5'h1E, pin_out_level = 5'h00;
   reg [4:0] analog_pin_config = 5'h15;
   wire [4:0] pin_level, sampled_level_ff, port_read_ff;
   wire busy_ff, done_ff, bit_tick_ff, holding_capacitor_connected_ff;
   wire [2:0] sampled_channel_ff;
   integer errors = 0, checked = 0, c, i, t;
   always #25 clock = ~clock;
   adccs_src_model SRC (
      .src_level(src_level),
      .port_a_direction(port_a_direction),
      .pin_out_level(pin_out_level),
      .pin_level(pin_level)
   );
   adccs_ctrl DUT (
      .clock(clock),
      .rst_b(rst_b),
      .conversion_clock_select(conversion_clock_select),
      .conversion_clock_double_select(conversion_clock_double_select),
      .input_channel_select(input_channel_select),
      .go(go),
      .pin_level(pin_level),
      .pin_out_level(pin_out_level),
      .port_a_direction(port_a_direction),
      .analog_pin_config(analog_pin_config),
      .busy_ff(busy_ff),
      .done_ff(done_ff),
      .bit_tick_ff(bit_tick_ff),
      .holding_capacitor_connected_ff(holding_capacitor_connected_ff),
      .sampled_channel_ff(sampled_channel_ff),
      .sampled_level_ff(sampled_level_ff),
      .port_read_ff(port_read_ff)
   );
   task check(input [31:0] seen, input [31:0] exp);
      begin
         checked = checked + 1;
         if (seen !== exp) begin
            errors = errors + 1;
            $display("wrong value at %0t: %0h, expected %0h", $time, seen, exp);
         end
      end
   endtask
   task wrap_up;
      begin
         $display("errors %0d checked %0d", errors, checked);
         if (errors == 0 && checked > 0) $display("DONE - PASS");
         else $display("DONE - FAIL");
         $finish;
      end
   endtask
   // one conversion; go stays up a second edge and comes again in recovery, both refused
   task conv(input [2:0] k, input integer n);
      begin
         conversion_clock_select = k[2:1];
         conversion_clock_double_select = k[0];
         input_channel_select = k;
         repeat (400) @(negedge clock);
         go = 1;
         repeat (2) @(negedge clock);
         go = 0;
         c = 1;
         t = 0;
         check(sampled_channel_ff, k);
         check(sampled_level_ff, 5'h1A);
         check(busy_ff, 1'b1);
         while (done_ff !== 1'b1 && c < 9000) begin
            @(negedge clock);
            c = c + 1;
            t = t + bit_tick_ff;
         end
         check(c, 9 * n);
         check(t, 9);
         check(busy_ff, 1'b0);
         go = 1;
         @(negedge clock);
         go = 0;
         c = c + 1;
         check(done_ff, 1'b0);
         while (holding_capacitor_connected_ff !== 1'b1 && c < 9000) begin
            @(negedge clock);
            c = c + 1;
         end
         check(c, 11 * n);
         check(busy_ff, 1'b0);
         if (c >= 9000) wrap_up;
      end
   endtask
   initial begin
      repeat (8) @(negedge clock);
      // outputs held at their idle values while reset is low
      check(busy_ff, 1'b0);
      check(done_ff, 1'b0);
      check(bit_tick_ff, 1'b0);
      check(holding_capacitor_connected_ff, 1'b1);
      check(port_read_ff, 5'h00);
      rst_b = 1;
      @(negedge clock);
      check(port_read_ff, 5'h0A);
      // all six divisors, then the rc source modelled as 80 cycles
      // rc runs awake here only to time it; firmware at this clock keeps it for sleep
      for (i = 0; i < 7; i = i + 1) conv(i[2:0], (i == 6) ? 80 : 2 << i);
      // at 50 ns the 32-period divisor is the shortest bit period inside 1.6-6.4 us
      conv(3'h4, 32);
      wrap_up;
   end
endmodule // adccs_ctrl_tb_top

//--- testbench/adccs_src_model.sv
// analog sources standing on the port pins
`timescale 1ns/1ns
module adccs_src_model (
   input wire [4:0] src_level,
   input wire [4:0] port_a_direction,
   input wire [4:0] pin_out_level,
   output wire [4:0] pin_level
);
   // an output pin overpowers its source and shows its own driven level
   assign pin_level = (src_level & port_a_direction) | (pin_out_level & ~port_a_direction);
endmodule // adccs_src_model
